// file: hw/scm_consts.svh
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
// Register byte offsets
`define SCM_A_CTRL 8'h00
`define SCM_A_ARMCNT 8'h04
`define SCM_A_POSTCNT 8'h08
`define SCM_A_STATUS 8'h0c
`define SCM_A_DATA 8'h10
`define SCM_A_RDPTR 8'h14
`define SCM_A_PLEN 8'h18
`define SCM_A_LBCNT 8'h1c
`define SCM_A_LIVE 8'h20
`define SCM_A_VOLT 8'h24
// Control field positions
`define SCM_C_START 0
`define SCM_C_PRE 1
`define SCM_C_NV 2
`define SCM_C_BDISC 3
`define SCM_C_MODE 4
`define SCM_C_LBLIVE 6
`define SCM_C_RANGE 8
// Status field positions
`define SCM_S_BUSY 0
`define SCM_S_DONE 1
`define SCM_S_AMP 2
`define SCM_S_NEG 3
`define SCM_S_POS 4
`define SCM_S_BATLOW 5
// Memory and partition figures
`define SCM_DEPTH 20'd524288
`define SCM_AW 19
`define SCM_NV_RES 20'd4
`define SCM_MAX_ARM 8'd128
// Microvolts per code on the 1 V range
`define SCM_UV_PER_CODE 10'd500
// Reserved converter codes
`define SCM_CODE_AMP 12'h800
`define SCM_CODE_NEG 12'h802
`define SCM_CODE_POS 12'h7ff
// Reset values
`define SCM_CTRL_RST 12'h000
`define SCM_ARMCNT_RST 8'h01
`define SCM_POSTCNT_RST 19'h00001
`endif

// file: hw/scm_pkg.sv
`default_nettype none
package scm_pkg;
	typedef enum {SCM_IDLE, SCM_PRE, SCM_POST} scm_state_t;
	typedef enum logic [1:0] {SCM_RD_A = 2'h0, SCM_RD_B = 2'h1, SCM_RD_AB = 2'h2} scm_rdmode_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} scm_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} scm_apb_rsp_t;
	typedef struct packed {
		logic [11:0] a;
		logic [11:0] b;
	} scm_pair_t;
endpackage
`default_nettype wire

// file: hw/scm_capture.sv
`include "scm_consts.svh"
`default_nettype none
module scm_capture (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire scm_pkg::scm_apb_req_t apb_req,
	output var scm_pkg::scm_apb_rsp_t apb_rsp,
	// Converter samples
	input wire logic adc_strobe,
	input wire scm_pkg::scm_pair_t adc_pair,
	// Arm and battery pins
	input wire logic arm_pin,
	input wire logic bat_low_pin,
	output var logic bat_disc,
	// Local bus
	output var logic lb_valid,
	output var logic [31:0] lb_data,
	input wire logic lb_ready
);
	import scm_pkg::*;

	localparam int AW = `SCM_AW;

	function automatic logic [2:0] part_shift(input logic [7:0] cnt);
		logic [2:0] sh;
		sh = 3'h0;
		for (int i = 0; i < 7; i++)
		begin
			if ((9'h001 << i) < {1'b0, cnt})
				sh = 3'(i + 1);
		end
		return sh;
	endfunction

	function automatic logic [15:0] packed16(input logic [11:0] code);
		return {code, 4'h0};
	endfunction

	function automatic logic [31:0] fmt_word(input scm_pair_t p, input logic [1:0] mode);
		logic [31:0] w;
		w = 32'h0;
		case (mode)
			SCM_RD_A: w = {16'h0, packed16(p.a)};
			SCM_RD_B: w = {16'h0, packed16(p.b)};
			default: w = {packed16(p.a), packed16(p.b)};
		endcase
		return w;
	endfunction

	function automatic logic [2:0] ovl_code(input logic [11:0] code);
		return {code == `SCM_CODE_POS, code == `SCM_CODE_NEG, code == `SCM_CODE_AMP};
	endfunction

	function automatic logic [9:0] uv_per_code(input logic [1:0] rng);
		logic [9:0] u;
		case (rng)
			2'h0: u = `SCM_UV_PER_CODE / 10'd10;
			2'h1: u = `SCM_UV_PER_CODE / 10'd5;
			2'h2: u = `SCM_UV_PER_CODE / 10'd2;
			default: u = `SCM_UV_PER_CODE;
		endcase
		return u;
	endfunction

	// Pin synchronisers
	logic [1:0] arm_s_q;
	logic [1:0] batl_s_q;
	logic arm_d1_q;
	logic arm_evt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			arm_s_q <= 2'h0;
			batl_s_q <= 2'h0;
			arm_d1_q <= 1'b0;
		end
		else if (clk_en)
		begin
			arm_s_q <= {arm_s_q[0], arm_pin};
			batl_s_q <= {batl_s_q[0], bat_low_pin};
			arm_d1_q <= arm_s_q[1];
		end
	end

	assign arm_evt = arm_s_q[1] & ~arm_d1_q;

	// Register state
	logic [11:0] ctrl_q;
	logic [7:0] armcnt_q;
	logic [18:0] postcnt_q;
	logic [2:0] ovl_q;
	logic done_q;
	scm_state_t state_q;
	logic pre_q;
	logic [2:0] psh_q;
	logic [6:0] part_q;
	logic [7:0] evt_q;
	logic [AW-1:0] wptr_q;
	logic [18:0] post_left_q;
	logic [AW-1:0] rd_addr_q;
	logic [19:0] lb_left_q;
	scm_pair_t ram_q;
	scm_pair_t live_q;
	logic [31:0] volt_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic lb_valid_q;
	logic [31:0] lb_data_q;

	logic setup;
	logic wr_en;
	logic rd_en;
	logic busy;
	logic start;
	logic pre_ok;
	logic [19:0] plen;
	logic [AW-1:0] waddr;
	logic wr_mem;
	logic wrap;
	logic finish;
	logic last_evt;
	logic data_err;
	logic pop_vme;
	logic pop_lb;
	logic lb_load;
	logic [AW-1:0] rd_next;
	logic mapped;
	logic [11:0] volt_code;

	assign setup = apb_req.psel & ~apb_req.penable;
	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
	assign busy = state_q != SCM_IDLE;
	assign start = wr_en & (apb_req.paddr == `SCM_A_CTRL) & apb_req.pwdata[`SCM_C_START] & ~busy;

	// Start takes the pre-arm bit from the same write
	assign pre_ok = (start ? apb_req.pwdata[`SCM_C_PRE] : ctrl_q[`SCM_C_PRE])
		& (armcnt_q != 8'h0) & (armcnt_q <= `SCM_MAX_ARM);
	assign plen = (`SCM_DEPTH >> psh_q) - (ctrl_q[`SCM_C_NV] ? `SCM_NV_RES : 20'h0);
	assign waddr = AW'({12'h0, part_q} << (5'(AW) - {2'h0, psh_q})) + wptr_q;
	assign wr_mem = adc_strobe & ((state_q == SCM_PRE & pre_q) | state_q == SCM_POST);
	assign wrap = {1'b0, wptr_q} == plen - 20'h1;
	assign finish = state_q == SCM_POST & adc_strobe & (post_left_q <= 19'h1 | (~pre_q & wrap));
	assign last_evt = (evt_q + 8'h1) == (pre_q ? armcnt_q : 8'h1);

	assign data_err = busy | (lb_left_q != 20'h0);
	assign pop_vme = rd_en & (apb_req.paddr == `SCM_A_DATA) & ~data_err;
	assign lb_load = ~lb_valid_q | lb_ready;
	assign pop_lb = lb_load & ~busy & (lb_left_q != 20'h0) & ~(ctrl_q[`SCM_C_LBLIVE] & busy);
	assign rd_next = rd_addr_q + AW'(pop_vme | pop_lb);

	always_comb
	begin
		case (apb_req.paddr)
			`SCM_A_CTRL, `SCM_A_ARMCNT, `SCM_A_POSTCNT, `SCM_A_STATUS, `SCM_A_DATA,
			`SCM_A_RDPTR, `SCM_A_PLEN, `SCM_A_LBCNT, `SCM_A_LIVE, `SCM_A_VOLT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `SCM_CTRL_RST;
			armcnt_q <= `SCM_ARMCNT_RST;
			postcnt_q <= `SCM_POSTCNT_RST;
		end
		else if (clk_en & wr_en & ~busy)
		begin
			case (apb_req.paddr)
				`SCM_A_CTRL: ctrl_q <= {apb_req.pwdata[11:1], 1'b0};
				`SCM_A_ARMCNT: armcnt_q <= apb_req.pwdata[7:0];
				`SCM_A_POSTCNT: postcnt_q <= apb_req.pwdata[18:0];
				default: ;
			endcase
		end
	end

	assign bat_disc = ctrl_q[`SCM_C_BDISC];

	// Capture sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= SCM_IDLE;
			pre_q <= 1'b0;
			psh_q <= 3'h0;
			part_q <= 7'h0;
			evt_q <= 8'h0;
			wptr_q <= '0;
			post_left_q <= 19'h0;
		end
		else if (clk_en)
		begin
			case (state_q)
				SCM_IDLE:
				begin
					pre_q <= pre_ok;
					psh_q <= pre_ok ? part_shift(armcnt_q) : 3'h0;
					if (start)
					begin
						part_q <= 7'h0;
						evt_q <= 8'h0;
						wptr_q <= '0;
						state_q <= SCM_PRE;
					end
				end
				SCM_PRE:
				begin
					if (wr_mem)
						wptr_q <= wrap ? '0 : wptr_q + AW'(1);
					if (arm_evt)
					begin
						post_left_q <= postcnt_q;
						state_q <= SCM_POST;
					end
				end
				SCM_POST:
				begin
					if (finish)
					begin
						evt_q <= evt_q + 8'h1;
						wptr_q <= '0;
						if (last_evt)
							state_q <= SCM_IDLE;
						else
						begin
							part_q <= part_q + 7'h1;
							state_q <= SCM_PRE;
						end
					end
					else if (adc_strobe)
					begin
						post_left_q <= post_left_q - 19'h1;
						wptr_q <= wrap ? '0 : wptr_q + AW'(1);
					end
				end
				default: state_q <= SCM_IDLE;
			endcase
		end
	end

	// Status flags, set wins over clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovl_q <= 3'h0;
			done_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_en & apb_req.paddr == `SCM_A_STATUS)
			begin
				ovl_q <= ovl_q & ~apb_req.pwdata[`SCM_S_POS:`SCM_S_AMP];
				done_q <= done_q & ~apb_req.pwdata[`SCM_S_DONE];
			end
			if (wr_mem)
				ovl_q <= ovl_q | ovl_code(adc_pair.a) | ovl_code(adc_pair.b);
			if (start)
				done_q <= 1'b0;
			else if (finish & last_evt)
				done_q <= 1'b1;
		end
	end

	// Single-ported sample memory, one array per channel
	logic [11:0] mem_a [0:`SCM_DEPTH-1];
	logic [11:0] mem_b [0:`SCM_DEPTH-1];

	always_ff @(posedge pclk)
	begin
		if (clk_en)
		begin
			if (wr_mem)
			begin
				mem_a[waddr] <= adc_pair.a;
				mem_b[waddr] <= adc_pair.b;
			end
			else if (~busy)
			begin
				ram_q.a <= mem_a[rd_next];
				ram_q.b <= mem_b[rd_next];
			end
		end
	end

	// Readout pointer, live sample, volt conversion
	assign volt_code = ctrl_q[`SCM_C_MODE +: 2] == SCM_RD_B ? ram_q.b : ram_q.a;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_addr_q <= '0;
			live_q <= '0;
			volt_q <= 32'h0;
		end
		else if (clk_en)
		begin
			if (wr_en & apb_req.paddr == `SCM_A_RDPTR & ~data_err)
				rd_addr_q <= apb_req.pwdata[AW-1:0];
			else
				rd_addr_q <= rd_next;
			if (busy & adc_strobe)
				live_q <= adc_pair;
			if (pop_vme)
				volt_q <= $signed({{20{volt_code[11]}}, volt_code})
					* $signed({22'h0, uv_per_code(ctrl_q[`SCM_C_RANGE +: 2])});
		end
	end

	// APB read data, registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end
		else if (clk_en & setup)
		begin
			pslverr_q <= ~mapped | (apb_req.paddr == `SCM_A_DATA & data_err)
				| (apb_req.pwrite & busy & apb_req.paddr != `SCM_A_STATUS);
			case (apb_req.paddr)
				`SCM_A_CTRL: prdata_q <= {20'h0, ctrl_q};
				`SCM_A_ARMCNT: prdata_q <= {24'h0, armcnt_q};
				`SCM_A_POSTCNT: prdata_q <= {13'h0, postcnt_q};
				`SCM_A_STATUS: prdata_q <= {7'h0, lb_left_q != 20'h0, 1'b0, part_q, 5'h0, psh_q,
					2'h0, batl_s_q[1], ovl_q, done_q, busy};
				`SCM_A_DATA: prdata_q <= data_err ? 32'h0
					: fmt_word(ram_q, ctrl_q[`SCM_C_MODE +: 2]);
				`SCM_A_RDPTR: prdata_q <= {13'h0, rd_addr_q};
				`SCM_A_PLEN: prdata_q <= {12'h0, plen};
				`SCM_A_LBCNT: prdata_q <= {12'h0, lb_left_q};
				`SCM_A_LIVE: prdata_q <= fmt_word(live_q, SCM_RD_AB);
				`SCM_A_VOLT: prdata_q <= volt_q;
				default: prdata_q <= 32'h0;
			endcase
		end
	end

	assign apb_rsp.prdata = prdata_q;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = pslverr_q;

	// Local bus stream
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lb_valid_q <= 1'b0;
			lb_data_q <= 32'h0;
			lb_left_q <= 20'h0;
		end
		else if (clk_en)
		begin
			if (wr_en & apb_req.paddr == `SCM_A_LBCNT & ~data_err)
				lb_left_q <= apb_req.pwdata[19:0];
			if (lb_load)
			begin
				lb_valid_q <= 1'b0;
				if (busy & ctrl_q[`SCM_C_LBLIVE] & adc_strobe)
				begin
					lb_valid_q <= 1'b1;
					lb_data_q <= fmt_word(adc_pair, ctrl_q[`SCM_C_MODE +: 2]);
				end
				else if (pop_lb)
				begin
					lb_valid_q <= 1'b1;
					lb_data_q <= fmt_word(ram_q, ctrl_q[`SCM_C_MODE +: 2]);
					lb_left_q <= lb_left_q - 20'h1;
				end
			end
		end
	end

	assign lb_valid = lb_valid_q;
	assign lb_data = lb_data_q;

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_no_read_busy;
		clk_en & setup & ~apb_req.pwrite & apb_req.paddr == `SCM_A_DATA & busy
			|=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
	endproperty
	a_no_read_busy: assert property (p_no_read_busy)
		else $error("data read allowed during capture");

	property p_part_count;
		clk_en & start & pre_ok |=> ((9'h001 << psh_q) >= {1'b0, $past(armcnt_q)})
			&& ((9'h001 << psh_q) < {$past(armcnt_q), 1'b0});
	endproperty
	a_part_count: assert property (p_part_count)
		else $error("partition count not smallest covering power of two");

	property p_no_part;
		clk_en & start & ~pre_ok |=> psh_q == 3'h0 && ~pre_q;
	endproperty
	a_no_part: assert property (p_no_part)
		else $error("memory partitioned without pre-arm or valid count");

	property p_pre_wrap;
		clk_en & state_q == SCM_PRE & wr_mem & wrap & ~arm_evt |=> wptr_q == '0 && state_q == SCM_PRE;
	endproperty
	a_pre_wrap: assert property (p_pre_wrap)
		else $error("pre-arm pointer did not wrap");

	property p_next_part;
		clk_en & finish & ~last_evt |=> state_q == SCM_PRE && part_q == $past(part_q) + 7'h1
			&& wptr_q == '0;
	endproperty
	a_next_part: assert property (p_next_part)
		else $error("next partition not selected after post-arm");

	property p_in_part;
		wr_mem |-> (waddr >> (5'(AW) - {2'h0, psh_q})) == AW'(part_q);
	endproperty
	a_in_part: assert property (p_in_part)
		else $error("write left its partition");

	property p_packed;
		lb_valid |-> lb_data[3:0] == 4'h0 && lb_data[19:16] == 4'h0;
	endproperty
	a_packed: assert property (p_packed)
		else $error("local bus word not left justified");

	property p_ovl_flag;
		clk_en & wr_mem & adc_pair.a == `SCM_CODE_AMP |=> ovl_q[0];
	endproperty
	a_ovl_flag: assert property (p_ovl_flag)
		else $error("amplifier overload code not flagged");

	property p_pop_adv;
		clk_en & pop_vme |=> rd_addr_q == $past(rd_addr_q) + AW'(1);
	endproperty
	a_pop_adv: assert property (p_pop_adv)
		else $error("data read did not advance readout");
endmodule
`default_nettype wire

// file: sim/scm_lb_sink.sv
`default_nettype none
module scm_lb_sink (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Local bus consumer
	input wire logic stall,
	output var logic lb_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_q;
	// Stall holds ready low two cycles of three
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 2'h0;
			lb_ready <= 1'b0;
		end
		else
		begin
			cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
			lb_ready <= !stall || (cnt_q == 2'h2);
		end
	end
endmodule
`default_nettype wire

// file: sim/segmented_capture_memory_tb.sv
`include "scm_consts.svh"
`default_nettype none
module segmented_capture_memory_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scm_pkg::*;
	localparam int PLEN = 4096;
	logic pclk, presetn, adc_strobe, arm_pin, bat_low_pin, stall, bat_disc, lb_valid, lb_ready;
	logic [31:0] lb_data, rd;
	logic err;
	scm_apb_req_t req;
	scm_apb_rsp_t rsp;
	scm_pair_t pair;
	logic [23:0] mem [int];
	logic [31:0] lbq [$];
	int n_fail, samples_checked, seed, ptr, base, s, t;
	int tbl [6] = '{1, 2, 5, 8, 9, 128};
	int uv [4] = '{50, 100, 250, 500};
	scm_capture scm_capture_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .apb_req(req),
		.apb_rsp(rsp), .adc_strobe(adc_strobe), .adc_pair(pair), .arm_pin(arm_pin),
		.bat_low_pin(bat_low_pin), .bat_disc(bat_disc), .lb_valid(lb_valid),
		.lb_data(lb_data), .lb_ready(lb_ready));
	scm_lb_sink scm_lb_sink_i (.pclk(pclk), .presetn(presetn), .stall(stall),
		.lb_ready(lb_ready));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	function automatic logic [31:0] fmt(input logic [23:0] v, input int m);
		if (m == 0)
			return {16'h0, v[23:12], 4'h0};
		if (m == 1)
			return {16'h0, v[11:0], 4'h0};
		return {v[23:12], 4'h0, v[11:0], 4'h0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task wait_done;
		t = 0;
		do
		begin
			apb(1'b0, `SCM_A_STATUS, 32'h0);
			t++;
		end
		while (rd[`SCM_S_DONE] !== 1'b1 && t < 20);
		chk(32'(rd[`SCM_S_DONE]), 32'h1);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task strobe(input logic [23:0] v);
		@(posedge pclk);
		adc_strobe <= 1'b1;
		pair <= v;
		mem[base + ptr % PLEN] = v;
		ptr++;
		lbq.push_back(fmt(v, 2));
		@(posedge pclk);
		adc_strobe <= 1'b0;
	endtask
	task rnd(input int n);
		logic [31:0] r;
		repeat (n)
		begin
			r = $random(seed);
			strobe(r[23:0]);
		end
	endtask
	task arm;
		@(posedge pclk);
		arm_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		arm_pin <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task drain;
		t = 0;
		while (lbq.size() > 0 && t < 200)
		begin
			@(posedge pclk);
			t++;
		end
		chk(32'(lbq.size()), 32'h0);
	endtask
	// Local bus monitor
	always @(posedge pclk)
		if (presetn === 1'b1 && lb_valid === 1'b1 && lb_ready === 1'b1)
			chk(lb_data, lbq.size() > 0 ? lbq.pop_front() : 32'hx);
	initial
	begin
		#400000;
		n_fail++;
		stop_test;
	end
	initial
	begin
		seed = 26129;
		n_fail = 0;
		samples_checked = 0;
		presetn = 1'b0;
		req = '0;
		adc_strobe = 1'b0;
		pair = '0;
		arm_pin = 1'b0;
		bat_low_pin = 1'b0;
		stall = 1'b0;
		base = 0;
		ptr = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`SCM_A_CTRL, 32'h0);
		rdchk(`SCM_A_ARMCNT, 32'h1);
		rdchk(`SCM_A_POSTCNT, 32'h1);
		apb(1'b0, 8'h28, 32'h0);
		chk(32'(err), 32'h1);
		$display("test reset done");
		bat_low_pin <= 1'b1;
		apb(1'b1, `SCM_A_CTRL, 32'h8);
		apb(1'b0, `SCM_A_STATUS, 32'h0);
		chk(32'(rd[`SCM_S_BATLOW]), 32'h1);
		chk(32'(bat_disc), 32'h1);
		bat_low_pin <= 1'b0;
		apb(1'b1, `SCM_A_CTRL, 32'h0);
		apb(1'b0, `SCM_A_STATUS, 32'h0);
		chk(32'(rd[`SCM_S_BATLOW]), 32'h0);
		chk(32'(bat_disc), 32'h0);
		$display("test battery done");
		foreach (tbl[i])
			for (int nv = 0; nv < 2; nv++)
			begin
				apb(1'b1, `SCM_A_CTRL, 32'(2 + 4 * nv));
				apb(1'b1, `SCM_A_ARMCNT, 32'(tbl[i]));
				s = 0;
				while ((1 << s) < tbl[i])
					s++;
				apb(1'b0, `SCM_A_STATUS, 32'h0);
				chk(32'(rd[10:8]), 32'(s));
				rdchk(`SCM_A_PLEN, 32'((524288 >> s) - 4 * nv));
			end
		apb(1'b1, `SCM_A_CTRL, 32'h0);
		apb(1'b1, `SCM_A_ARMCNT, 32'h8);
		apb(1'b0, `SCM_A_STATUS, 32'h0);
		chk(32'(rd[10:8]), 32'h0);
		rdchk(`SCM_A_PLEN, 32'd524288);
		$display("test partitions done");
		apb(1'b1, `SCM_A_ARMCNT, 32'd128);
		apb(1'b1, `SCM_A_POSTCNT, 32'h4);
		apb(1'b1, `SCM_A_CTRL, 32'h63);
		strobe(24'h800802);
		strobe(24'h7ff000);
		rnd(PLEN + 8);
		rdchk(`SCM_A_DATA, 32'h0);
		apb(1'b1, `SCM_A_ARMCNT, 32'h5);
		apb(1'b0, `SCM_A_STATUS, 32'h0);
		chk(32'(rd[`SCM_S_BUSY]), 32'h1);
		arm;
		rnd(4);
		for (int p = 1; p < 128; p++)
		begin
			base = p * PLEN;
			ptr = 0;
			rnd(2);
			arm;
			rnd(4);
		end
		wait_done;
		chk(32'(rd[4:0]), 32'h1e);
		rdchk(`SCM_A_LIVE, fmt(mem[127 * PLEN + 5], 2));
		drain;
		rdchk(`SCM_A_ARMCNT, 32'd128);
		apb(1'b1, `SCM_A_STATUS, 32'h1c);
		apb(1'b0, `SCM_A_STATUS, 32'h0);
		chk(32'(rd[4:2]), 32'h0);
		$display("test capture done");
		apb(1'b1, `SCM_A_RDPTR, 32'h0);
		for (int k = 0; k < 16; k++)
			rdchk(`SCM_A_DATA, fmt(mem[k], 2));
		for (int m = 0; m < 3; m++)
		begin
			apb(1'b1, `SCM_A_CTRL, 32'(2 + 16 * m));
			apb(1'b1, `SCM_A_RDPTR, 32'(PLEN + m));
			rdchk(`SCM_A_DATA, fmt(mem[PLEN + m], m));
		end
		for (int r = 0; r < 4; r++)
		begin
			apb(1'b1, `SCM_A_CTRL, 32'(32'h22 + 256 * r));
			apb(1'b1, `SCM_A_RDPTR, 32'(r));
			apb(1'b0, `SCM_A_DATA, 32'h0);
			rdchk(`SCM_A_VOLT, 32'(int'($signed(mem[r][23:12])) * uv[r]));
		end
		$display("test readout done");
		stall <= 1'b1;
		apb(1'b1, `SCM_A_RDPTR, 32'(PLEN));
		for (int k = 0; k < 6; k++)
			lbq.push_back(fmt(mem[PLEN + k], 2));
		apb(1'b1, `SCM_A_LBCNT, 32'h6);
		apb(1'b0, `SCM_A_STATUS, 32'h0);
		chk(32'(rd[24]), 32'h1);
		rdchk(`SCM_A_DATA, 32'h0);
		drain;
		stall <= 1'b0;
		apb(1'b1, `SCM_A_RDPTR, 32'h0);
		for (int k = 0; k < 8; k++)
			lbq.push_back(fmt(mem[k], 2));
		apb(1'b1, `SCM_A_LBCNT, 32'h8);
		t = 0;
		while (lbq.size() > 0 && t < 50)
		begin
			@(posedge pclk);
			t++;
		end
		chk(32'(t <= 10), 32'h1);
		drain;
		$display("test local bus done");
		apb(1'b1, `SCM_A_POSTCNT, 32'h3);
		apb(1'b1, `SCM_A_CTRL, 32'h1);
		base = 0;
		ptr = 0;
		arm;
		rnd(3);
		lbq.delete();
		wait_done;
		apb(1'b1, `SCM_A_RDPTR, 32'h0);
		for (int k = 0; k < 3; k++)
			rdchk(`SCM_A_DATA, fmt(mem[k], 0));
		$display("test single partition done");
		stop_test;
	end
endmodule
`default_nettype wire
